// ### event_capture_pkg.sv
// shared constants and types of the event capture device and its host bridge
// assumes a single 250 MHz pclk for both ends
package event_capture_pkg;
    localparam int NUM_CH = 16;
    localparam int CH_W = 4;
    localparam int WORD_W = 16;
    localparam int BUF_WORDS = 64;
    localparam int BUF_EVENTS = 32;
    localparam int CNT_W = 7;
    localparam int FILT_W = 6;
    localparam int SINCE_W = 7;
    localparam int CHG_W = 3;
    // timing, each figure in its own unit
    localparam int CLK_MHZ = 250;
    localparam int SCAN_US = 125;
    localparam int MS_US = 1000;
    localparam int FILTER_MS = 4;
    localparam int CHATTER_MS = 100;
    localparam int CHATTER_CHANGES = 4;
    localparam int SCAN_CYCLES_DEF = SCAN_US * CLK_MHZ;
    localparam int MS_CYCLES_DEF = MS_US * CLK_MHZ;
    // exact division, so least and longest rounding agree
    localparam int FILTER_SCANS = FILTER_MS * MS_US / SCAN_US;
    // module bus word addresses
    localparam logic [6:0] MB_MASK = 7'h00;
    localparam logic [6:0] MB_CTRL = 7'h01;
    localparam logic [6:0] MB_TIME = 7'h02;
    localparam logic [6:0] MB_STATUS = 7'h03;
    localparam logic [6:0] MB_CHATTER = 7'h04;
    localparam logic [6:0] MB_STATE = 7'h05;
    localparam int MB_BUF_BIT = 6;
    localparam int CTRL_CRIT_BIT = 0;
    // event identifier word: channel in low bits, new level at this bit
    localparam int EV_STATE_BIT = 8;
    // reset values
    localparam logic [15:0] MASK_RST = 16'h0000;
    localparam logic [15:0] TIME_RST = 16'h0000;
    localparam logic [6:0] SINCE_RST = 7'h7f;
    // apb map of the bridge
    localparam logic [7:0] APB_CMD = 8'h00;
    localparam logic [7:0] APB_RDATA = 8'h04;
    localparam logic [7:0] APB_STATUS = 8'h08;
    localparam logic [7:0] APB_IRQ_STAT = 8'h0c;
    localparam logic [7:0] APB_IRQ_MASK = 8'h10;
    localparam int CMD_WE_BIT = 8;
    localparam int CMD_WDATA_LSB = 16;
    localparam int STAT_WORDS_LSB = 8;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_REFUSED = 1;
    localparam int IRQ_W = 2;
    typedef enum logic [0:0] {SCAN_IDLE = 1'b0, SCAN_EVAL = 1'b1} scan_state_t;
    typedef enum logic [0:0] {HOST_IDLE = 1'b0, HOST_WAIT = 1'b1} host_state_t;
endpackage : event_capture_pkg

// ### event_capture_sva.sv
// concurrent checks on the module bus and the device outputs
// assumes one pclk domain; sits beside the bus interface in the bench
`timescale 1ns/1ps
`default_nettype none
module event_capture_sva
    import event_capture_pkg::*;
#(
    parameter int unsigned SCAN_CYCLES = SCAN_CYCLES_DEF
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req,
    input wire logic we,
    input wire logic [6:0] addr,
    input wire logic [15:0] wdata,
    input wire logic ack,
    input wire logic [15:0] rdata,
    input wire logic [NUM_CH-1:0] field_in,
    input wire logic [NUM_CH-1:0] field_state,
    input wire logic [NUM_CH-1:0] chatter_flag
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // a raw level must stand this long before the filter may pass it
    localparam int unsigned HOLD_MIN = (FILTER_SCANS - 1) * SCAN_CYCLES;
    int unsigned age [NUM_CH];
    logic [NUM_CH-1:0] prev_in;
    logic [NUM_CH-1:0] prev_state;
    logic [NUM_CH-1:0] early;
    // age of each raw level, saturating so it never wraps
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_in <= '0;
            prev_state <= '0;
            for (int i = 0; i < NUM_CH; i++)
                age[i] <= 0;
        end
        else
        begin
            prev_in <= field_in;
            prev_state <= field_state;
            for (int i = 0; i < NUM_CH; i++)
                age[i] <= (field_in[i] != prev_in[i]) ? 0 : ((age[i] < HOLD_MIN) ? age[i] + 1 : age[i]);
        end
    end
    // accepted change whose raw level is younger than the window
    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
            early[i] = (field_state[i] != prev_state[i]) && (age[i] < HOLD_MIN);
    end
    sequence s_take;
        req && !ack;
    endsequence
    sequence s_answer;
        ack ##1 !ack;
    endsequence
    chk_ack_timing: assert property (s_take |=> s_answer)
        else $error("bus request not answered by a one cycle ack");
    chk_ack_cause: assert property (!req |=> !ack)
        else $error("ack without a request");
    chk_req_hold: assert property (s_take |=> req && $stable(addr) && $stable(we) && $stable(wdata))
        else $error("request changed before ack");
    chk_filter_age: assert property (early == '0)
        else $error("state change passed before the filter window");
    chk_unmapped_zero: assert property (s_take and (!we && addr > MB_STATE && !addr[MB_BUF_BIT]) |=> rdata == 16'h0000)
        else $error("unmapped bus read not zero");
    chk_status_words: assert property (s_take and (!we && addr == MB_STATUS) |=> rdata <= 16'h0040 && !rdata[0])
        else $error("status word count out of range or odd");
    chk_id_layout: assert property (s_take and (!we && addr[MB_BUF_BIT] && !addr[0]) |=> (rdata & 16'hfef0) == 16'h0000)
        else $error("identifier word has stray bits");
    chk_chatter_clear: assert property ((($past(chatter_flag) & ~chatter_flag) != '0) |-> ack && !we && addr == MB_CHATTER)
        else $error("chatter flag fell without a chatter read");
endmodule : event_capture_sva
`default_nettype wire

// ### event_sequence_capture_tb.sv
// bench: apb master, field stimulus and a scoreboard of read results
// assumes bridge and device meet over module_bus_if on one pclk
`timescale 1ns/1ps
`default_nettype none
module event_sequence_capture_tb;
    import event_capture_pkg::*;
    // short scan and millisecond so filter and chatter windows fit the run
    localparam int unsigned SCAN_T = 64;
    localparam int unsigned MS_T = 200;
    localparam int unsigned SETTLE = (FILTER_SCANS + 2) * SCAN_T;
    typedef struct packed {logic [33:0] val; logic [33:0] msk;} note_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [NUM_CH-1:0] field_in, field_state, chatter_flag;
    logic [15:0] rnd;
    note_t notes[$];
    note_t cur;
    int mismatches, samples_checked, cycles, words;
    module_bus_if mb();
    io_controller_bridge i_io_controller_bridge (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .mb(mb));
    event_sequence_module #(.SCAN_CYCLES(SCAN_T), .MS_CYCLES(MS_T)) i_event_sequence_module (.pclk(pclk),
        .presetn(presetn), .mb(mb), .field_in(field_in), .field_state(field_state), .chatter_flag(chatter_flag));
    event_capture_sva #(.SCAN_CYCLES(SCAN_T)) i_event_capture_sva (.pclk(pclk), .presetn(presetn), .req(mb.req),
        .we(mb.we), .addr(mb.addr), .wdata(mb.wdata), .ack(mb.ack), .rdata(mb.rdata), .field_in(field_in),
        .field_state(field_state), .chatter_flag(chatter_flag));
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic report_and_stop();
        if (mismatches == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    // one apb transfer; a read leaves its expectation for the monitor
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e,
        input logic [33:0] m);
        @(posedge pclk);
        if (!wr)
            notes.push_back('{e, m});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // device access through the bridge: command, poll busy, fetch data
    task automatic dev(input logic wr, input logic [6:0] a, input logic [15:0] d, input logic [15:0] e,
        input logic [15:0] m);
        apb(1'b1, APB_CMD, {d, 7'h00, wr, 1'b0, a}, '0, '0);
        rd = 32'h1;
        while (rd[0])
            apb(1'b0, APB_STATUS, '0, '0, '0);
        if (!wr)
            apb(1'b0, APB_RDATA, '0, {18'h0, e}, {18'h0, m});
    endtask : dev
    task automatic hold(input logic [15:0] v);
        field_in <= v;
        repeat (SETTLE) @(posedge pclk);
    endtask : hold
    // scoreboard: oldest note against each read completion
    always @(posedge pclk)
    begin
        if (psel && penable && pready && !pwrite)
        begin
            cur = notes.pop_front();
            if (cur.msk != '0)
            begin
                samples_checked++;
                if ((({irq, pslverr, prdata} ^ cur.val) & cur.msk) !== '0)
                begin
                    mismatches++;
                    $display("Error read %h: expected %h seen %h", paddr, cur.val & cur.msk,
                        {irq, pslverr, prdata} & cur.msk);
                end
            end
        end
    end
    // cut a hang short well past the expected run length
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            mismatches++;
            $display("Error timeout: expected finish seen %0d cycles", cycles);
            report_and_stop();
        end
    end
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        field_in = '0;
        mismatches = 0;
        samples_checked = 0;
        rnd = 16'($urandom(16585));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, unmapped places, refused read and the interrupt
        apb(1'b1, APB_IRQ_MASK, 32'h3, '0, '0);
        apb(1'b0, 8'h14, '0, {2'b01, 32'h0}, {2'b01, 32'h0});
        dev(1'b0, MB_MASK, '0, MASK_RST, 16'hffff);
        dev(1'b0, MB_CTRL, '0, 16'h0000, 16'h0001);
        dev(1'b0, MB_STATUS, '0, 16'h0000, 16'hffff);
        dev(1'b0, 7'h20, '0, 16'h0000, 16'hffff);
        dev(1'b0, 7'h40, '0, '0, '0);
        apb(1'b0, APB_IRQ_STAT, '0, {2'b10, 32'h2}, {2'b10, 32'h2});
        apb(1'b0, APB_STATUS, '0, '0, {2'b10, 32'h1});
        apb(1'b1, APB_IRQ_MASK, '0, '0, '0);
        dev(1'b1, MB_TIME, 16'h0100, '0, '0);
        apb(1'b0, APB_STATUS, '0, '0, {2'b10, 32'h0});
        apb(1'b1, APB_IRQ_MASK, 32'h3, '0, '0);
        dev(1'b1, MB_MASK, rnd, '0, '0);
        dev(1'b0, MB_MASK, '0, rnd, 16'hffff);
        dev(1'b1, MB_MASK, 16'h0004, '0, '0);
        // a short pulse dies; a held level passes on the enabled channel only
        field_in <= 16'h0024;
        repeat (10 * SCAN_T) @(posedge pclk);
        hold(16'h0000);
        dev(1'b0, MB_STATE, '0, 16'h0000, 16'h0004);
        dev(1'b0, MB_STATUS, '0, 16'h0000, 16'hffff);
        hold(16'h0024);
        dev(1'b0, MB_STATE, '0, 16'h0004, 16'h0004);
        dev(1'b0, MB_STATUS, '0, 16'h0002, 16'hffff);
        dev(1'b0, 7'h40, '0, 16'h0102, 16'hffff);
        dev(1'b0, 7'h41, '0, 16'h0100, 16'hff00);
        dev(1'b0, MB_STATUS, '0, 16'h0000, 16'hffff);
        // three sweeps: rate chatter, clear on read, then overflow
        dev(1'b1, MB_MASK, 16'hffff, '0, '0);
        hold(16'hffff);
        dev(1'b0, MB_CHATTER, '0, 16'h0000, 16'hffff);
        hold(16'h0000);
        dev(1'b0, MB_CHATTER, '0, 16'hffff, 16'hffff);
        dev(1'b0, MB_CHATTER, '0, 16'h0000, 16'hffff);
        hold(16'hffff);
        dev(1'b0, MB_STATUS, '0, '0, '0);
        words = int'(rd[15:0]);
        for (int i = 0; i < words; i++)
            dev(1'b0, 7'h40 + 7'(i), '0, '0, '0);
        dev(1'b0, MB_STATUS, '0, 16'h0040, 16'hffff);
        for (int i = 0; i < BUF_WORDS; i++)
            dev(1'b0, 7'h40 + 7'(i), '0, '0, (i % 2 == 0) ? 16'hfef0 : 16'h0000);
        // counting rule: the fourth change since the swap flags, the three before it do not
        dev(1'b1, MB_CTRL, 16'h0001, '0, '0);
        dev(1'b0, MB_CTRL, '0, 16'h0001, 16'h0001);
        hold(16'hfffd);
        dev(1'b0, MB_CHATTER, '0, '0, '0);
        hold(16'hfffc);
        hold(16'hfffd);
        hold(16'hfffc);
        dev(1'b0, MB_CHATTER, '0, 16'h0000, 16'h0001);
        hold(16'hfffd);
        dev(1'b0, MB_CHATTER, '0, 16'h0001, 16'h0001);
        report_and_stop();
    end
endmodule : event_sequence_capture_tb
`default_nettype wire

// ### event_sequence_module.sv
// sixteen-channel sequence-of-events capture with two ping-pong event buffers
// assumes field inputs are asynchronous and the host holds req until ack
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - watch sixteen open/closed field inputs
// - reject state changes shorter than four milliseconds
// - host writes per-channel tagging mask
// - one chatter flag per channel
// - each event stores changed channel index
// - sample enabled channels every 125 microseconds
// - masked-off channels are never evaluated
// - host writes millisecond time reference to all
// - control bit selects chatter criterion
// - criterion one: changes closer than 100 ms
// - criterion two: four changes between buffer reads
// - two buffers of thirty-two events
// - capture writes one buffer, host reads other
// - each buffer sixty-four words, ids and times
// - memory control picks write and read buffer
// - host reads status before reading buffer words
module event_sequence_module
    import event_capture_pkg::*;
#(
    parameter int unsigned SCAN_CYCLES = SCAN_CYCLES_DEF,
    parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
)
(
    input wire logic pclk,
    input wire logic presetn,
    module_bus_if.device mb,
    input wire logic [NUM_CH-1:0] field_in,
    output logic [NUM_CH-1:0] field_state,
    output logic [NUM_CH-1:0] chatter_flag
);
    logic [NUM_CH-1:0] sync1;
    logic [NUM_CH-1:0] sync2;
    logic [NUM_CH-1:0] sampled;
    logic [NUM_CH-1:0] mask;
    logic crit_count;
    logic [15:0] scan_cnt;
    logic [17:0] ms_cnt;
    logic [WORD_W-1:0] time_ms;
    scan_state_t state;
    logic [CH_W-1:0] ch;
    logic [FILT_W-1:0] filt_cnt [NUM_CH];
    logic [SINCE_W-1:0] since_ms [NUM_CH];
    logic [CHG_W-1:0] chg_cnt [NUM_CH];
    logic [WORD_W-1:0] buf_mem [2][BUF_WORDS];
    logic [CNT_W-1:0] buf_cnt [2];
    logic wr_sel;
    logic rd_done;
    logic wr_fire;
    logic rd_fire;
    logic scan_tick;
    logic ms_tick;
    logic accept;
    logic store;
    logic swap;
    logic [CNT_W-1:0] rd_cnt;
    logic [5:0] rd_idx;
    logic [5:0] wr_idx;

    // request decode; ack gating stops one held request firing twice
    assign wr_fire = mb.req & ~mb.ack & mb.we;
    assign rd_fire = mb.req & ~mb.ack & ~mb.we;
    assign scan_tick = (scan_cnt == 16'(SCAN_CYCLES - 1));
    assign ms_tick = (ms_cnt == 18'(MS_CYCLES - 1));
    assign rd_idx = mb.addr[5:0];
    assign wr_idx = buf_cnt[wr_sel][5:0];

    // a change is taken once it has held for the whole filter window
    assign accept = (state == SCAN_EVAL) & mask[ch] & (sampled[ch] != field_state[ch])
                    & (filt_cnt[ch] == FILT_W'(FILTER_SCANS - 1));
    assign store = accept & (buf_cnt[wr_sel] < CNT_W'(BUF_WORDS));

    // readable buffer reports zero words once fully read
    assign rd_cnt = rd_done ? '0 : buf_cnt[~wr_sel];
    assign swap = rd_done & (buf_cnt[wr_sel] != '0);

    // two-flop synchroniser on the field inputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1 <= '0;
            sync2 <= '0;
        end
        else
        begin
            sync1 <= field_in;
            sync2 <= sync1;
        end
    end

    // scan timer; all channels are snapped at one instant, then walked one per cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scan_cnt <= '0;
            state <= SCAN_IDLE;
            ch <= '0;
            sampled <= '0;
        end
        else
        begin
            scan_cnt <= scan_tick ? '0 : scan_cnt + 16'd1;
            unique case (state)
                SCAN_IDLE:
                begin
                    if (scan_tick)
                    begin
                        sampled <= sync2;
                        ch <= '0;
                        state <= SCAN_EVAL;
                    end
                end
                SCAN_EVAL:
                begin
                    ch <= ch + 4'd1;
                    if (ch == CH_W'(NUM_CH - 1))
                    begin
                        state <= SCAN_IDLE;
                    end
                end
            endcase
        end
    end

    // event time: a host write reloads it and restarts the millisecond phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ms_cnt <= '0;
            time_ms <= TIME_RST;
        end
        else if (wr_fire && mb.addr == MB_TIME)
        begin
            time_ms <= mb.wdata;
            ms_cnt <= '0;
        end
        else if (ms_tick)
        begin
            ms_cnt <= '0;
            time_ms <= time_ms + 16'd1;
        end
        else
        begin
            ms_cnt <= ms_cnt + 18'd1;
        end
    end

    // host configuration
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask <= MASK_RST;
            crit_count <= 1'b0;
        end
        else if (wr_fire)
        begin
            if (mb.addr == MB_MASK)
            begin
                mask <= mb.wdata;
            end
            if (mb.addr == MB_CTRL)
            begin
                crit_count <= mb.wdata[CTRL_CRIT_BIT];
            end
        end
    end

    // per-channel filter; a masked channel keeps its level and its filter idles
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            field_state <= '0;
            for (int i = 0; i < NUM_CH; i++)
            begin
                filt_cnt[i] <= '0;
            end
        end
        else if (state == SCAN_EVAL)
        begin
            if (!mask[ch] || sampled[ch] == field_state[ch])
            begin
                filt_cnt[ch] <= '0;
            end
            else if (accept)
            begin
                filt_cnt[ch] <= '0;
                field_state[ch] <= sampled[ch];
            end
            else
            begin
                filt_cnt[ch] <= filt_cnt[ch] + 6'd1;
            end
        end
    end

    // chatter tracking; a set in the cycle of a clearing read wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chatter_flag <= '0;
            for (int i = 0; i < NUM_CH; i++)
            begin
                since_ms[i] <= SINCE_RST;
                chg_cnt[i] <= '0;
            end
        end
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (ms_tick && since_ms[i] != SINCE_RST)
                begin
                    since_ms[i] <= since_ms[i] + 7'd1;
                end
                if (swap)
                begin
                    chg_cnt[i] <= '0;
                end
            end
            if (rd_fire && mb.addr == MB_CHATTER)
            begin
                chatter_flag <= '0;
            end
            if (accept)
            begin
                since_ms[ch] <= '0;
                if (chg_cnt[ch] != CHG_W'(CHATTER_CHANGES))
                begin
                    chg_cnt[ch] <= chg_cnt[ch] + 3'd1;
                end
                if (crit_count ? (chg_cnt[ch] >= CHG_W'(CHATTER_CHANGES - 1))
                               : (since_ms[ch] < SINCE_W'(CHATTER_MS)))
                begin
                    chatter_flag[ch] <= 1'b1;
                end
            end
        end
    end

    // event storage; data only, gated by the word count, so no reset needed
    always_ff @(posedge pclk)
    begin
        if (store)
        begin
            buf_mem[wr_sel][wr_idx] <= {{(WORD_W - EV_STATE_BIT - 1){1'b0}}, sampled[ch],
                                        {(EV_STATE_BIT - CH_W){1'b0}}, ch};
            buf_mem[wr_sel][wr_idx + 6'd1] <= time_ms;
        end
    end

    // memory control: which buffer fills, which one the host drains
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_sel <= 1'b0;
            rd_done <= 1'b1;
            buf_cnt[0] <= '0;
            buf_cnt[1] <= '0;
        end
        else
        begin
            if (store)
            begin
                buf_cnt[wr_sel] <= buf_cnt[wr_sel] + 7'd2;
            end
            if (swap)
            begin
                wr_sel <= ~wr_sel;
                buf_cnt[~wr_sel] <= '0;
                rd_done <= 1'b0;
            end
            else if (rd_fire && mb.addr[MB_BUF_BIT] && {1'b0, rd_idx} == rd_cnt - 7'd1)
            begin
                rd_done <= 1'b1;
            end
        end
    end

    // bus answer one cycle after the request is seen
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mb.ack <= 1'b0;
            mb.rdata <= '0;
        end
        else
        begin
            mb.ack <= mb.req & ~mb.ack;
            if (rd_fire && mb.addr[MB_BUF_BIT])
            begin
                mb.rdata <= ({1'b0, rd_idx} < rd_cnt) ? buf_mem[~wr_sel][rd_idx] : '0;
            end
            else if (rd_fire)
            begin
                case (mb.addr)
                    MB_MASK: mb.rdata <= mask;
                    MB_CTRL: mb.rdata <= {15'h0000, crit_count};
                    MB_TIME: mb.rdata <= time_ms;
                    MB_STATUS: mb.rdata <= {9'h000, rd_cnt};
                    MB_CHATTER: mb.rdata <= chatter_flag;
                    MB_STATE: mb.rdata <= field_state;
                    default: mb.rdata <= '0;
                endcase
            end
        end
    end
endmodule : event_sequence_module
`default_nettype wire

// ### io_controller_bridge.sv
// host end: apb slave that turns commands into module bus transfers
// assumes the device answers every request with one ack pulse
`timescale 1ns/1ps
`default_nettype none
module io_controller_bridge
    import event_capture_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    module_bus_if.host mb
);
    host_state_t state;
    logic ap_fire;
    logic cmd_wr;
    logic cmd_buf_read;
    logic set_refused;
    logic set_done;
    logic mapped;
    logic [15:0] resp;
    logic [31:0] last_cmd;
    logic [CNT_W-1:0] valid_words;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;

    // apb access is taken on its first access cycle, pready is registered
    assign ap_fire = psel & penable & ~pready;
    assign cmd_wr = ap_fire & pwrite & (paddr == APB_CMD);
    assign cmd_buf_read = ~pwdata[CMD_WE_BIT] & pwdata[MB_BUF_BIT];
    // a buffer read past the word count last reported is not sent
    assign set_refused = cmd_wr & (state == HOST_IDLE) & cmd_buf_read
                         & ({1'b0, pwdata[5:0]} >= valid_words);
    assign set_done = (state == HOST_WAIT) & mb.ack;
    assign mapped = (paddr == APB_CMD) | (paddr == APB_RDATA) | (paddr == APB_STATUS)
                    | (paddr == APB_IRQ_STAT) | (paddr == APB_IRQ_MASK);

    // command sequencer; a command while busy is dropped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= HOST_IDLE;
            mb.req <= 1'b0;
            mb.we <= 1'b0;
            mb.addr <= '0;
            mb.wdata <= '0;
            resp <= '0;
            last_cmd <= '0;
            valid_words <= '0;
        end
        else
        begin
            unique case (state)
                HOST_IDLE:
                begin
                    if (cmd_wr && !set_refused)
                    begin
                        mb.req <= 1'b1;
                        mb.we <= pwdata[CMD_WE_BIT];
                        mb.addr <= pwdata[6:0];
                        mb.wdata <= pwdata[CMD_WDATA_LSB +: 16];
                        last_cmd <= pwdata;
                        state <= HOST_WAIT;
                    end
                end
                HOST_WAIT:
                begin
                    if (mb.ack)
                    begin
                        mb.req <= 1'b0;
                        state <= HOST_IDLE;
                        if (!mb.we)
                        begin
                            resp <= mb.rdata;
                        end
                        if (!mb.we && mb.addr == MB_STATUS)
                        begin
                            valid_words <= mb.rdata[CNT_W-1:0];
                        end
                        else if (!mb.we && mb.addr[MB_BUF_BIT] && {1'b0, mb.addr[5:0]} == valid_words - 7'd1)
                        begin
                            valid_words <= '0; // status must be read again
                        end
                    end
                end
            endcase
        end
    end

    // interrupt status, read to clear; a new event in the same cycle stays set
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_status <= '0;
            irq_mask <= '0;
            irq <= 1'b0;
        end
        else
        begin
            if (ap_fire && !pwrite && paddr == APB_IRQ_STAT)
            begin
                irq_status <= {set_refused, set_done};
            end
            else
            begin
                irq_status <= irq_status | {set_refused, set_done};
            end
            if (ap_fire && pwrite && paddr == APB_IRQ_MASK)
            begin
                irq_mask <= pwdata[IRQ_W-1:0];
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // apb answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else
        begin
            pready <= psel & penable & ~pready;
            pslverr <= ap_fire & ~mapped;
            if (ap_fire && !pwrite)
            begin
                case (paddr)
                    APB_CMD: prdata <= last_cmd;
                    APB_RDATA: prdata <= {16'h0000, resp};
                    APB_STATUS: prdata <= {17'h00000, valid_words, 7'h00, state == HOST_WAIT};
                    APB_IRQ_STAT: prdata <= {30'h00000000, irq_status};
                    APB_IRQ_MASK: prdata <= {30'h00000000, irq_mask};
                    default: prdata <= '0;
                endcase
            end
        end
    end
endmodule : io_controller_bridge
`default_nettype wire

// ### module_bus_if.sv
// module bus between the host bridge and the event capture device
// assumes both ends run on the same pclk; no clocking block
`timescale 1ns/1ps
`default_nettype none
interface module_bus_if;
    logic req;
    logic we;
    logic [6:0] addr;
    logic [15:0] wdata;
    logic ack;
    logic [15:0] rdata;
    modport device (input req, input we, input addr, input wdata, output ack, output rdata);
    modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface : module_bus_if
`default_nettype wire
